// ### design/alarm_clear_and_message_ctrl.sv
// alarm status clear handling and automatic alarm/warning message control
`timescale 1ns/1ps
// Operation
// [RULE1] a clear command drops the system alarm and returns to full operation if no cause remains.
// [RULE2] an alarm caused only by the driver alarm ends as soon as the driver alarm ends.
// [RULE3] a non-driver alarm present with a driver alarm keeps the system alarm after the driver alarm ends.
// [RULE4] a cause still present after a clear puts the device back into the alarm state.
// [RULE5] non-clearable alarms stay asserted through a clear command.
// [RULE6] after a successful clear the current code reads zero while the history is kept.
// [RULE7] the message setting is 0 for none (factory), 1 for alarms only, 2 for alarms and warnings.
// [RULE8] a newly written message setting governs messages at once.
// [RULE9] at power-up the message setting is restored from the saved value and unsaved changes are lost.
// [RULE10] with no saved value the factory default is loaded at power-up.
// [RULE11] each automatic message goes out once when its condition is first detected; of causes rising together at most one is reported, other alarm first.
module alarm_clear_and_message_ctrl
   import alarm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   // command strobes from the text command interpreter
   input wire logic clear_alarm_command,
   input wire logic set_message_command,
   input wire logic [1:0] set_message_value,
   input wire logic save_parameters_command,
   // nonvolatile store image presented at power-up
   input wire logic nv_valid,
   input wire logic [1:0] nv_message_value,
   // alarm sources
   input wire logic driver_alarm,
   input wire logic other_alarm,
   input wire logic [7:0] other_alarm_code,
   input wire logic other_alarm_clearable,
   input wire logic [7:0] driver_alarm_code,
   input wire logic warning,
   input wire logic [7:0] warning_code,
   // outputs
   output logic system_alarm,
   output logic full_operation,
   output logic [7:0] current_alarm_code,
   output logic [7:0] history_newest,
   output logic [1:0] alarm_message_setting,
   output logic nv_write,
   output logic [1:0] nv_write_value,
   output logic msg_valid,
   output logic [1:0] msg_kind,
   output logic [7:0] msg_code
);
   import alarm_pkg::*;

   // ***********************************************
   // reset release
   // ***********************************************
   logic rst_meta;
   logic rst_n;
   // two-stage release so deassertion is clean against clk_sys
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ***********************************************
   // alarm status
   // ***********************************************
   logic other_latched;
   logic other_fixed;
   logic prev_other;
   logic prev_driver;
   logic [7:0] hist [HIST_DEPTH];
   logic other_rise;
   logic driver_rise;

   assign other_rise = other_alarm & ~prev_other;
   assign driver_rise = driver_alarm & ~prev_driver;

   // edge history of the raw causes
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prev_other <= 1'b0;
         prev_driver <= 1'b0;
      end else begin
         prev_other <= other_alarm;
         prev_driver <= driver_alarm;
      end
   end

   // non-driver alarms latch until cleared; set wins over clear
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         other_latched <= 1'b0;
         other_fixed <= 1'b0;
      end else if (other_alarm) begin
         other_latched <= 1'b1; // RULE4
         other_fixed <= other_fixed | ~other_alarm_clearable;
      end else if (clear_alarm_command && !other_fixed) begin // RULE5
         other_latched <= 1'b0; // RULE1
      end
      // non-clearable alarm ignores the clear until reset
   end

   // driver alarm follows the driver directly; latched others hold it RULE2 RULE3
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         system_alarm <= 1'b0;
         full_operation <= 1'b1;
      end else begin
         system_alarm <= driver_alarm | other_latched | other_alarm; // RULE2 RULE3
         full_operation <= ~(driver_alarm | other_latched | other_alarm); // RULE1
      end
   end

   // current code and history; a clear zeroes only the current code
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         current_alarm_code <= CODE_NONE;
         for (int i = 0; i < HIST_DEPTH; i++) begin
            hist[i] <= CODE_NONE;
         end
      end else if (other_rise || driver_rise) begin
         current_alarm_code <= other_rise ? other_alarm_code : driver_alarm_code;
         hist[0] <= other_rise ? other_alarm_code : driver_alarm_code;
         for (int i = 1; i < HIST_DEPTH; i++) begin
            hist[i] <= hist[i-1];
         end
      end else if (!driver_alarm && !other_latched && !other_alarm && system_alarm) begin
         current_alarm_code <= CODE_NONE; // RULE6
      end else if (clear_alarm_command && !other_fixed && !other_alarm && !driver_alarm) begin
         current_alarm_code <= CODE_NONE; // RULE6
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         history_newest <= CODE_NONE;
      end else begin
         history_newest <= hist[0];
      end
   end

   // ***********************************************
   // message setting
   // ***********************************************
   logic loaded;
   logic [1:0] saved;
   // the saved image is caught once after reset release, never under reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         loaded <= 1'b0;
         alarm_message_setting <= MSG_FACTORY; // RULE10
         saved <= MSG_FACTORY;
      end else if (!loaded) begin
         loaded <= 1'b1;
         alarm_message_setting <= nv_valid ? nv_message_value : MSG_FACTORY; // RULE9 RULE10
         saved <= nv_valid ? nv_message_value : MSG_FACTORY;
      end else if (set_message_command && set_message_value <= MSG_ALARM_WARN) begin
         alarm_message_setting <= set_message_value; // RULE7 RULE8
      end else if (save_parameters_command) begin
         saved <= alarm_message_setting;
      end
   end

   // save request to the nonvolatile store
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         nv_write <= 1'b0;
         nv_write_value <= MSG_FACTORY;
      end else begin
         nv_write <= loaded & save_parameters_command & ~set_message_command;
         nv_write_value <= alarm_message_setting;
      end
   end

   // ***********************************************
   // automatic messages
   // ***********************************************
   logic prev_warn;
   logic warn_rise;
   assign warn_rise = warning & ~prev_warn;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prev_warn <= 1'b0;
      end else begin
         prev_warn <= warning;
      end
   end

   // one message per new detection; alarms take priority over warnings
   // limitation: a warning rising in the same cycle as an alarm is not reported
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         msg_valid <= 1'b0;
         msg_kind <= KIND_ALARM;
         msg_code <= CODE_NONE;
      end else begin
         msg_valid <= 1'b0;
         if ((other_rise || driver_rise) && alarm_message_setting != MSG_NONE) begin
            msg_valid <= 1'b1; // RULE11 RULE8
            msg_kind <= KIND_ALARM;
            msg_code <= other_rise ? other_alarm_code : driver_alarm_code;
         end else if (warn_rise && alarm_message_setting == MSG_ALARM_WARN) begin
            msg_valid <= 1'b1; // RULE11 RULE7
            msg_kind <= KIND_WARN;
            msg_code <= warning_code;
         end
      end
   end
endmodule

// ### inc/alarm_pkg.sv
// constants shared by the alarm clear and message control block
package alarm_pkg;
   // message setting encodings
   localparam logic [1:0] MSG_NONE = 2'h0;
   localparam logic [1:0] MSG_ALARM_ONLY = 2'h1;
   localparam logic [1:0] MSG_ALARM_WARN = 2'h2;
   localparam logic [1:0] MSG_FACTORY = MSG_NONE;
   // code width, history depth and the no-alarm code
   localparam int CODE_W = 8;
   localparam int HIST_DEPTH = 10;
   localparam logic [7:0] CODE_NONE = 8'h00;
   // message kinds on the message port
   localparam logic [1:0] KIND_ALARM = 2'h1;
   localparam logic [1:0] KIND_WARN = 2'h2;
endpackage

// ### verif/alarm_ctrl_chk.sv
// port assertions for the alarm clear and message control block
`timescale 1ns/1ps
module alarm_ctrl_chk
   import alarm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic clear_alarm_command,
   input wire logic set_message_command,
   input wire logic [1:0] set_message_value,
   input wire logic driver_alarm,
   input wire logic other_alarm,
   input wire logic other_alarm_clearable,
   input wire logic system_alarm,
   input wire logic full_operation,
   input wire logic [7:0] current_alarm_code,
   input wire logic [1:0] alarm_message_setting
);
   logic [2:0] up;
   logic lat, nc;
   wire rdy = up == 3'h7;
   wire calm = !driver_alarm && !other_alarm;
   // cycles since release; commands only come once this saturates
   always_ff @(posedge clk_sys or negedge resetn)
      if (!resetn) up <= 3'h0;
      else if (!rdy) up <= up + 3'h1;
   // latched non-driver cause and a sticky flag for non-clearable ones
   always_ff @(posedge clk_sys or negedge resetn)
      if (!resetn) {lat, nc} <= 2'b00;
      else {lat, nc} <= {other_alarm | (lat & ~(clear_alarm_command & ~nc)), nc | (other_alarm & ~other_alarm_clearable)};
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   a_op_inverse: assert property (full_operation == !system_alarm) else $error("bad full op");
   // the latch drops on the clear edge, the status register follows one edge later
   sequence clear_settled;
      ##1 (!system_alarm && current_alarm_code == CODE_NONE);
   endsequence
   a_clear_ok: assert property (rdy && clear_alarm_command && calm && !nc |=> clear_settled)
      else $error("clear failed");
   a_cause_back: assert property (rdy && !calm |=> system_alarm) else $error("alarm missing");
   a_drv_ends: assert property (rdy && calm && !lat |=> !system_alarm) else $error("alarm stuck");
   a_other_holds: assert property (lat && !clear_alarm_command |=> system_alarm) else $error("alarm lost");
   a_stuck: assert property (nc |=> system_alarm [*2]) else $error("non-clearable cleared");
   a_set_now: assert property (rdy && set_message_command && set_message_value != 2'h3 |=>
      alarm_message_setting == $past(set_message_value)) else $error("setting late");
   a_set_bad: assert property (rdy && set_message_command && set_message_value == 2'h3 |=>
      $stable(alarm_message_setting)) else $error("bad setting taken");
endmodule

// ### verif/nv_image.sv
// nonvolatile image of the message setting, outliving every reset
`timescale 1ns/1ps
module nv_image (
   input wire logic clk_sys,
   input wire logic nv_write,
   input wire logic [1:0] nv_write_value,
   output logic nv_valid = 1'b0,
   output logic [1:0] nv_message_value = 2'h3
);
   // empty until the first save; the stale 3 must never be loaded
   always @(posedge clk_sys)
      if (nv_write) {nv_valid, nv_message_value} <= {1'b1, nv_write_value};
endmodule

// ### verif/test_alarm_clear_and_message_ctrl.sv
// self-checking bench for the alarm clear and message control block
`timescale 1ns/1ps
module test_alarm_clear_and_message_ctrl;
   import alarm_pkg::*;
   logic clk_sys = 0, resetn = 0, clear_alarm_command = 0, set_message_command = 0, save_parameters_command = 0;
   logic driver_alarm = 0, other_alarm = 0, other_alarm_clearable = 1, warning = 0, ea, lat, nc, enw;
   logic system_alarm, full_operation, nv_write, nv_valid, msg_valid;
   logic [1:0] set_message_value = 0, alarm_message_setting, nv_message_value, msg_kind, nv_write_value, es;
   logic [7:0] other_alarm_code = 0, driver_alarm_code = 0, warning_code = 0, current_alarm_code, history_newest;
   logic [7:0] msg_code, mc;
   logic [31:0] seed = 85211;
   int errors = 0, n_tests = 0, nmsg = 0, up = 0;
   alarm_clear_and_message_ctrl dut (.*);
   nv_image nv (.*);
   always #4 clk_sys = ~clk_sys;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      if (errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic power_up();
      resetn = 0;
      repeat (16) @(negedge clk_sys);
      resetn = 1;
      repeat (10) @(negedge clk_sys);
   endtask
   // one command cycle; other and warning codes change only as their cause rises so messages can be matched, the driver code changes on every call
   task automatic go(input logic d, o, k, w, c, s, p, input logic [1:0] v, input int n);
      @(negedge clk_sys);
      seed = lfsr(seed);
      if (o && !other_alarm) other_alarm_code = seed[7:0];
      if (w && !warning) warning_code = seed[15:8];
      driver_alarm_code = seed[23:16];
      {driver_alarm, other_alarm, other_alarm_clearable, warning} = {d, o, k, w};
      {clear_alarm_command, set_message_command, save_parameters_command, set_message_value} = {c, s, p, v};
      @(negedge clk_sys);
      {clear_alarm_command, set_message_command, save_parameters_command} = 3'b000;
      repeat (n) @(negedge clk_sys);
   endtask
   // cycle model: the clear is blocked for good once a non-clearable cause was seen
   always @(posedge clk_sys or negedge resetn)
      if (!resetn) begin
         up = 0;
         {lat, nc, ea, enw} = 4'h0;
      end else begin
         if (up < 7)
            es = nv_valid ? nv_message_value : MSG_FACTORY;
         else if (set_message_command && set_message_value != 2'h3)
            es = set_message_value;
         up += int'(up < 7);
         enw = save_parameters_command && !set_message_command;
         // the status register sees the latch as it stood before this edge
         ea = driver_alarm | lat | other_alarm;
         lat = other_alarm | (lat & ~(clear_alarm_command & ~nc));
         nc |= other_alarm & ~other_alarm_clearable;
      end
   // compare with the model once commands are accepted
   always @(negedge clk_sys)
      if (up == 7 && resetn) begin
         chk(system_alarm, ea);
         chk(full_operation, !ea);
         chk(alarm_message_setting, es);
         chk(nv_write, enw);
         if (!ea)
            chk(current_alarm_code, CODE_NONE);
         if (msg_valid === 1'b1)
            {nmsg, mc} = {nmsg + 1, msg_code};
      end
   initial begin
      power_up();
      go(1, 0, 1, 0, 0, 0, 0, 0, 3);
      go(0, 0, 1, 0, 0, 0, 0, 0, 3);
      chk(nmsg, 0);
      for (int v = 0; v < 4; v++)
         go(0, 0, 1, 0, 0, 1, 1, 2'(v), 1);
      go(0, 0, 1, 0, 0, 1, 0, MSG_ALARM_ONLY, 1);
      go(0, 0, 1, 0, 0, 0, 1, 0, 1);
      go(0, 1, 1, 0, 0, 0, 0, 0, 4);
      go(0, 1, 1, 0, 1, 0, 0, 0, 2);
      go(0, 0, 1, 0, 1, 0, 0, 0, 3);
      chk(nmsg, 1);
      chk(mc, other_alarm_code);
      chk(history_newest, other_alarm_code);
      go(0, 0, 1, 1, 0, 0, 0, 0, 3);
      go(0, 0, 1, 0, 0, 1, 0, MSG_ALARM_WARN, 1);
      go(0, 0, 1, 1, 0, 0, 0, 0, 3);
      chk(nmsg, 2);
      chk(mc, warning_code);
      go(1, 1, 1, 0, 0, 0, 0, 0, 2);
      go(0, 1, 1, 0, 0, 0, 0, 0, 2);
      go(0, 0, 1, 0, 1, 0, 0, 0, 2);
      go(1, 0, 1, 0, 0, 0, 0, 0, 2);
      go(0, 1, 0, 0, 0, 0, 0, 0, 2);
      go(0, 0, 1, 0, 1, 0, 0, 0, 3);
      power_up();
      // saved alarms-only survives, the unsaved alarms-and-warnings is lost
      chk(alarm_message_setting, MSG_ALARM_ONLY);
      close_out();
   end
endmodule
bind alarm_clear_and_message_ctrl alarm_ctrl_chk chk_i (.*);
